//--- scd_consts.svh
/*
 * Constants of the system clock source and divider block.
 * Assumes inclusion by the package, the design module and the checker only.
 */
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// Source select codes
`define SCD_SRC_MAIN 2'h0
`define SCD_SRC_INT 2'h1
`define SCD_SRC_INT_DIV4 2'h2
`define SCD_SRC_SLOW 2'h3

// Field widths
`define SCD_DIV_W 4
`define SCD_DIV_EXT_W 6
`define SCD_CRYSTAL_SELECT_W 4
`define SCD_PERIPH_N 32
`define SCD_RATIO_W 7

// Divisor codes
`define SCD_DIV_RESET 4'hf
`define SCD_DIV_PLL_MIN 7'h04

// Reset crystal choice and first code usable as PLL reference
`define SCD_CRYSTAL_SELECT_RESET 4'h0
`define SCD_CRYSTAL_SELECT_PLL_MIN 4'h4

// Relock count in main oscillator cycles
`define SCD_RELOCK_COUNT 13'h1200
`define SCD_RELOCK_W 13

`endif

//--- scd_pkg.sv
/*
 * Types of the system clock source and divider block.
 * Assumes scd_consts.svh is on the include path.
 */
`include "scd_consts.svh"

package scd_pkg;

  typedef enum logic [2:0] {
    SCD_CLK_MAIN = 3'b000,
    SCD_CLK_INT = 3'b001,
    SCD_CLK_INT_DIV4 = 3'b010,
    SCD_CLK_SLOW = 3'b011,
    SCD_CLK_PLL = 3'b100
  } scd_clk_src_t;

  typedef logic [`SCD_DIV_EXT_W-1:0] scd_div_ext_t;
  typedef logic [`SCD_RATIO_W-1:0] scd_ratio_t;

endpackage

//--- scd_system_clock.sv
/*
 * Run-mode system clock generation: source selection, PLL relock guard,
 * glitch-free divider, crystal translation and per-peripheral gates.
 * Assumes oscillator and PLL clocks arrive as levels far slower than
 * clk_sys, and that configuration ports come from software-held registers.
 */
`timescale 1ns/1ps
`include "scd_consts.svh"


module scd_system_clock
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Clock sources
  input wire logic internal_osc,
  input wire logic main_osc,
  input wire logic slow_osc,
  input wire logic pll_out,
  // Basic configuration
  input wire logic pll_skip,
  input wire logic [1:0] osc_source_select,
  input wire logic [`SCD_DIV_W-1:0] sys_clock_divisor,
  input wire logic divider_use,
  input wire logic pll_power_down,
  input wire logic [`SCD_CRYSTAL_SELECT_W-1:0] crystal_select,
  // Extended configuration
  input wire logic ext_config_select,
  input wire logic pll_skip_ext,
  input wire logic [1:0] osc_source_select_ext,
  input wire scd_pkg::scd_div_ext_t sys_clock_divisor_ext,
  input wire logic pll_power_down_ext,
  // Peripheral gates
  input wire logic [`SCD_PERIPH_N-1:0] periph_clock_enable,
  // Outputs
  output logic system_clock,
  output logic [`SCD_PERIPH_N-1:0] periph_clock,
  output logic pll_enable,
  output logic [`SCD_CRYSTAL_SELECT_W-1:0] pll_config,
  output logic pll_ready,
  output scd_pkg::scd_clk_src_t active_source
);
  import scd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [1:0] div4_cnt;
  logic div4_level;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= {pll_out, slow_osc, main_osc, internal_osc};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Internal oscillator divided by four
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div4_cnt <= 2'h0;
    end else if (sync2[0] && !sync3[0]) begin
      div4_cnt <= div4_cnt + 2'h1;
    end
  end

  assign div4_level = div4_cnt[1];

  logic div4_prev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div4_prev <= 1'b0;
    end else begin
      div4_prev <= div4_level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Effective configuration

  logic eff_bypass;
  logic [1:0] eff_src;
  logic eff_pwrdn;
  scd_ratio_t eff_ratio;

  always_comb begin
    if (ext_config_select) begin
      eff_bypass = pll_skip_ext;
      eff_src = osc_source_select_ext;
      eff_pwrdn = pll_power_down_ext;
      eff_ratio = {1'b0, sys_clock_divisor_ext} + 7'h01;
    end else begin
      eff_bypass = pll_skip;
      eff_src = osc_source_select;
      eff_pwrdn = pll_power_down;
      eff_ratio = {3'h0, sys_clock_divisor} + 7'h01;
      if (!divider_use && eff_bypass) begin
        eff_ratio = 7'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PLL enable, crystal translation and relock counter

  logic [`SCD_RELOCK_W-1:0] relock_cnt;
  logic [`SCD_CRYSTAL_SELECT_W-1:0] last_crystal_select;
  logic relock_start;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_enable <= 1'b0;
    end else begin
      pll_enable <= !eff_pwrdn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_crystal_select <= `SCD_CRYSTAL_SELECT_RESET;
      pll_config <= `SCD_CRYSTAL_SELECT_RESET;
    end else begin
      last_crystal_select <= crystal_select;
      if (crystal_select >= `SCD_CRYSTAL_SELECT_PLL_MIN) begin
        pll_config <= crystal_select;
      end
    end
  end

  assign relock_start = (crystal_select != last_crystal_select) || (!eff_pwrdn && !pll_enable);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      relock_cnt <= `SCD_RELOCK_COUNT;
    end else if (relock_start) begin
      relock_cnt <= `SCD_RELOCK_COUNT;
    end else if (pll_enable && relock_cnt != '0 && sync2[1] && !sync3[1]) begin
      relock_cnt <= relock_cnt - 13'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_ready <= 1'b0;
    end else begin
      pll_ready <= pll_enable && !relock_start && relock_cnt == '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source and ratio request

  scd_clk_src_t req_src;
  scd_ratio_t req_ratio;

  always_comb begin
    req_ratio = eff_ratio;
    if (!eff_bypass && eff_src == `SCD_SRC_MAIN && pll_ready) begin
      req_src = SCD_CLK_PLL;
      if (eff_ratio < `SCD_DIV_PLL_MIN) begin
        req_ratio = `SCD_DIV_PLL_MIN;
      end
    end else begin
      unique case (eff_src)
        `SCD_SRC_MAIN: req_src = SCD_CLK_MAIN;
        `SCD_SRC_INT: req_src = SCD_CLK_INT;
        `SCD_SRC_INT_DIV4: req_src = SCD_CLK_INT_DIV4;
        `SCD_SRC_SLOW: req_src = SCD_CLK_SLOW;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Glitch-free divider counting source half periods

  scd_ratio_t cur_ratio;
  logic [`SCD_RATIO_W:0] half_cnt;
  logic src_edge;
  logic at_wrap;
  logic next_sys;
  logic resync;
  logic src_change;

  assign src_change = req_src != active_source;

  always_comb begin
    unique case (active_source)
      SCD_CLK_MAIN: src_edge = sync2[1] ^ sync3[1];
      SCD_CLK_INT: src_edge = sync2[0] ^ sync3[0];
      SCD_CLK_INT_DIV4: src_edge = div4_level ^ div4_prev;
      SCD_CLK_SLOW: src_edge = sync2[2] ^ sync3[2];
      SCD_CLK_PLL: src_edge = sync2[3] ^ sync3[3];
      default: src_edge = 1'b0;
    endcase
  end

  assign at_wrap = half_cnt == {cur_ratio, 1'b0} - 8'h01;

  // Switch only at the end of a low phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_source <= SCD_CLK_INT;
      cur_ratio <= 7'h01;
      half_cnt <= '0;
      resync <= 1'b0;
    end else if (src_edge) begin
      if (resync) begin
        resync <= 1'b0;
      end else if (at_wrap) begin
        half_cnt <= '0;
        active_source <= req_src;
        cur_ratio <= req_ratio;
        resync <= src_change;
      end else begin
        half_cnt <= half_cnt + 8'h01;
      end
    end
  end

  always_comb begin
    next_sys = system_clock;
    if (src_edge) begin
      next_sys = resync || (at_wrap ? !src_change : half_cnt + 8'h01 < {1'b0, cur_ratio});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      system_clock <= 1'b0;
    end else begin
      system_clock <= next_sys;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral clock gates, changed only while the clock is low

  logic [`SCD_PERIPH_N-1:0] gate;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gate <= '0;
    end else if (!system_clock && !next_sys) begin
      gate <= periph_clock_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      periph_clock <= '0;
    end else begin
      periph_clock <= {`SCD_PERIPH_N{next_sys}} & gate;
    end
  end

endmodule // scd_system_clock

//--- scd_system_clock_props.sv
/*
 * Checker of the system clock block.
 * Assumes binding to scd_system_clock and scd_consts.svh on the include path.
 */
`timescale 1ns/1ps
`include "scd_consts.svh"

module scd_system_clock_props
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic pll_skip,
  input wire logic [1:0] osc_source_select,
  input wire logic pll_power_down,
  input wire logic [`SCD_CRYSTAL_SELECT_W-1:0] crystal_select,
  input wire logic ext_config_select,
  input wire logic pll_skip_ext,
  input wire logic [1:0] osc_source_select_ext,
  input wire logic pll_power_down_ext,
  // Outputs
  input wire logic system_clock,
  input wire logic [`SCD_PERIPH_N-1:0] periph_clock,
  input wire logic pll_enable,
  input wire logic [`SCD_CRYSTAL_SELECT_W-1:0] pll_config,
  input wire logic pll_ready,
  input wire scd_pkg::scd_clk_src_t active_source
);
  logic eff_pd;
  logic eff_skip;
  logic [1:0] eff_src;
  logic [15:0] lock_cnt;

  ////////////////////////////////////////////////////////////////
  // Effective fields and cycles since a PLL change
  assign eff_pd = ext_config_select ? pll_power_down_ext : pll_power_down;
  assign eff_skip = ext_config_select ? pll_skip_ext : pll_skip;
  assign eff_src = ext_config_select ? osc_source_select_ext : osc_source_select;

  always_ff @(posedge clk_sys) begin
    if (rst || eff_pd || !$stable(crystal_select)) begin
      lock_cnt <= 16'h0;
    end else if (lock_cnt != 16'hffff) begin
      lock_cnt <= lock_cnt + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reset; disable iff (1'b0) rst |=> !system_clock && !pll_enable && !pll_ready
    && active_source == SCD_CLK_INT && pll_config == 4'h0; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_pll_power; !rst |=> pll_enable == !$past(eff_pd); endproperty
  a_pll_power: assert property (p_pll_power) else $error("pll enable wrong");
  property p_pll_entry; $rose(active_source == SCD_CLK_PLL) |-> pll_ready && pll_enable; endproperty
  a_pll_entry: assert property (p_pll_entry) else $error("pll used unlocked");
  property p_pll_path; $rose(active_source == SCD_CLK_PLL) |-> !eff_skip && eff_src == 2'h0; endproperty
  a_pll_path: assert property (p_pll_path) else $error("pll used while bypassed");
  property p_relock; $rose(pll_ready) |-> lock_cnt >= 16'h1200; endproperty
  a_relock: assert property (p_relock) else $error("lock too early");
  property p_same_crystal_select; pll_ready && $stable(crystal_select) && lock_cnt >= 16'h8 |=> pll_ready; endproperty
  a_same_crystal_select: assert property (p_same_crystal_select) else $error("lock lost without change");
  property p_xlate; crystal_select >= 4'h4 ##1 $stable(crystal_select) |-> pll_config == crystal_select;
  endproperty
  a_xlate: assert property (p_xlate) else $error("translation wrong");
  property p_gate; periph_clock != 32'h0 |-> system_clock; endproperty
  a_gate: assert property (p_gate) else $error("peripheral clock not gated");
  property p_phase; $changed(system_clock) |=> $stable(system_clock); endproperty
  a_phase: assert property (p_phase) else $error("system clock phase shortened");
endmodule // scd_system_clock_props

bind scd_system_clock scd_system_clock_props i_scd_system_clock_props (.*);

//--- scd_system_clock_tb.sv
/*
 * Testbench of the system clock block.
 * Assumes the sources are slow squares made from clk_sys ticks.
 */
`timescale 1ns/1ps

module scd_system_clock_tb;
  import scd_pkg::*;
  logic clk_sys = 0, rst = 1, internal_osc = 0, main_osc = 0, slow_osc = 0, pll_out = 0;
  logic pll_skip = 1, divider_use = 0, pll_power_down = 1, ext_config_select = 0;
  logic pll_skip_ext = 1, pll_power_down_ext = 1, system_clock, pll_enable, pll_ready;
  logic [1:0] osc_source_select = 2'h1, osc_source_select_ext = 2'h0;
  logic [3:0] sys_clock_divisor = 4'h5, crystal_select = 4'h0, pll_config;
  logic [31:0] periph_clock_enable = 32'h0, periph_clock;
  scd_div_ext_t sys_clock_divisor_ext = 6'h0;
  scd_clk_src_t active_source;
  int miscompares = 0, n_compared = 0, tick = 0, t_lock = 0;
  int half[4] = '{2, 3, 12, 5};

  scd_system_clock i_scd_system_clock (.*);

  always #25 clk_sys = ~clk_sys;

  // Sources: main, internal, pll, slow
  always @(posedge clk_sys) begin
    tick <= tick + 1;
    main_osc <= tick % 4 < 2;
    internal_osc <= tick % 6 < 3;
    pll_out <= tick % 8 < 4;
    slow_osc <= tick % 10 < 5;
  end

  ////////////////////////////////////////////////////////////////
  // Tasks
  task automatic report_and_stop;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic rise;
    logic prev;
    prev = system_clock;
    for (int k = 0; k < 2000; k++) begin
      @(negedge clk_sys);
      if (prev === 1'b0 && system_clock === 1'b1) return;
      prev = system_clock;
    end
    miscompares++;
    report_and_stop;
  endtask

  // Period of system_clock in clk_sys cycles
  task automatic meas(input int exp);
    int t0;
    repeat (3) rise;
    t0 = tick;
    rise;
    chk(tick - t0, exp);
  endtask

  ////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({system_clock, pll_enable, pll_ready, pll_config}, 7'h0);
    chk(active_source, SCD_CLK_INT);
    @(posedge clk_sys);
    rst <= 1'b0;
    periph_clock_enable <= 32'h5;
    meas(6);
    for (int k = 0; k < 24; k++) begin
      @(negedge clk_sys);
      chk(periph_clock, {29'h0, system_clock, 1'b0, system_clock});
    end
    @(posedge clk_sys);
    divider_use <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      osc_source_select <= s[1:0];
      sys_clock_divisor <= 4'(s * 5);
      meas(2 * (s * 5 + 1) * half[s]);
      chk(active_source, s);
    end
    @(posedge clk_sys);
    ext_config_select <= 1'b1;
    sys_clock_divisor_ext <= 6'h3f;
    meas(256);
    chk(active_source, SCD_CLK_MAIN);
    @(posedge clk_sys);
    ext_config_select <= 1'b0;
    crystal_select <= 4'h4;
    osc_source_select <= 2'h0;
    sys_clock_divisor <= 4'h3;
    pll_skip <= 1'b0;
    pll_power_down <= 1'b0;
    t_lock = tick;
    repeat (2) @(negedge clk_sys);
    chk(pll_enable, 1);
    repeat (100) @(negedge clk_sys);
    chk({pll_ready, active_source}, {1'b0, SCD_CLK_MAIN});
    for (int k = 0; k < 30000 && pll_ready !== 1'b1; k++) @(negedge clk_sys);
    chk(pll_ready, 1);
    chk(tick - t_lock > 32'h1200 * 4 - 32, 1);
    meas(32);
    chk({active_source, pll_config}, {SCD_CLK_PLL, 4'h4});
    @(posedge clk_sys);
    sys_clock_divisor <= 4'h0;
    crystal_select <= 4'h4;
    meas(32);
    chk(pll_ready, 1);
    @(posedge clk_sys);
    crystal_select <= 4'h5;
    repeat (20) @(negedge clk_sys);
    chk(pll_ready, 0);
    repeat (300) @(negedge clk_sys);
    chk({active_source, pll_config}, {SCD_CLK_MAIN, 4'h5});
    @(posedge clk_sys);
    pll_power_down <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(pll_enable, 0);
    report_and_stop;
  end
endmodule // scd_system_clock_tb
